// ---- spc_defs.svh ----
// Constants for the single pulse / capture timer block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// Register byte addresses on the AHB-Lite slave
`define SPC_ADDR_CTRL    32'h0000_0000
`define SPC_ADDR_CMPA    32'h0000_0004
`define SPC_ADDR_CMPP    32'h0000_0008
`define SPC_ADDR_STAT    32'h0000_000c

// Counter
`define SPC_CNT_W        10
`define SPC_CNT_MAX      10'h3ff
`define SPC_CNT_ZERO     10'h000
`define SPC_CNT_ONE      10'h001

// Control register layout and reset value
`define SPC_CTRL_W       11
`define SPC_CTRL_RST     11'h000
`define SPC_RUN_BIT      4

// Status register fields
`define SPC_STAT_FLAG_A  16
`define SPC_STAT_FLAG_P  17

// Mode and pin function encodings
`define SPC_MODE_CAPTURE 2'b01
`define SPC_MODE_PULSE   2'b10
`define SPC_PF_RISE      2'b00
`define SPC_PF_FALL      2'b01
`define SPC_PF_BOTH      2'b10
`define SPC_PF_NONE      2'b11

// Timer clock prescaler terminal counts
`define SPC_DIV_W        6
`define SPC_DIV_1        6'h00
`define SPC_DIV_4        6'h03
`define SPC_DIV_16       6'h0f
`define SPC_DIV_64       6'h3f

`endif

// ---- spc_pkg.sv ----
// Types shared by the single pulse / capture timer.
// Assumes spc_defs.svh is on the include path.
`default_nettype none
`include "spc_defs.svh"

package spc_pkg;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic       duty_period_swap;
      logic       clear_source_select;
      logic       output_polarity_invert;
      logic       output_initial_level;
      logic       counter_run_bit;
      logic [1:0] pin_function;
      logic [1:0] mode_select;
   } spc_ctrl_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
   } spc_aphase_t;

   typedef enum {
      SPC_OP_IDLE,
      SPC_OP_PULSE,
      SPC_OP_CAPTURE
   } spc_op_t;

endpackage

`default_nettype wire

// ---- spc_timer.sv ----
// Single pulse output and capture input timer with an AHB-Lite slave.
// Assumes one clock hclk; the pins are asynchronous and are synchronised here.
`default_nettype none
`include "spc_defs.svh"

module spc_timer
   import spc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   input  wire logic        external_trigger_pin,
   input  wire logic        capture_input_pin,
   output var  logic        timer_out,
   output var  logic        timer_out_en,
   output var  logic        compare_a_req,
   output var  logic        compare_p_req
);

   // Register state
   spc_ctrl_t                ctrl_q;
   spc_ctrl_t                ctrl_d;
   logic [`SPC_CNT_W-1:0]    cmpa_q;
   logic [`SPC_CNT_W-1:0]    cmpa_d;
   logic [`SPC_CNT_W-1:0]    cmpp_q;
   logic [`SPC_CNT_W-1:0]    cmpp_d;
   logic [`SPC_CNT_W-1:0]    cnt_q;
   logic [`SPC_CNT_W-1:0]    cnt_d;
   logic [`SPC_CNT_W-1:0]    cnt_inc;
   logic                     run_prev_q;
   logic                     active_q;
   logic                     active_d;
   logic                     flag_a_q;
   logic                     flag_a_d;
   logic                     flag_p_q;
   logic                     flag_p_d;
   logic [`SPC_DIV_W-1:0]    div_q;
   logic [`SPC_DIV_W-1:0]    div_lim;
   logic                     tick;

   // Bus
   spc_aphase_t              aph_q;
   logic                     take;
   logic                     wr_en;
   logic                     wr_ctrl;
   logic                     wr_cmpa;
   logic                     wr_cmpp;
   logic                     wr_stat;
   logic [31:0]              rdata;
   logic                     sel_ctrl;
   logic                     sel_cmpa;
   logic                     sel_cmpp;
   logic                     sel_stat;

   // Pins
   logic [1:0]               pin_raw;
   logic [1:0]               s1_q;
   logic [1:0]               s2_q;
   logic [1:0]               s3_q;
   logic [1:0]               filt_q;
   logic [1:0]               filt_prev_q;

   // Events
   spc_op_t                  op;
   logic                     run;
   logic                     run_rise;
   logic                     run_fall;
   logic                     trig_edge;
   logic                     cap_rise;
   logic                     cap_fall;
   logic                     cap_hit;
   logic                     cap_on_rise;
   logic                     cap_on_fall;
   logic                     cap_on_both;
   logic                     match_a;
   logic                     match_p;
   logic                     set_a;
   logic                     pin_level;

   // Pin synchronisers: three stages, a change counts once stages two and
   // three agree, so a one-cycle glitch at stage two never reaches logic.
   // Pin to event latency is about four hclk cycles.
   assign pin_raw = {capture_input_pin, external_trigger_pin};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1_q[gi]        <= 1'b0;
               s2_q[gi]        <= 1'b0;
               s3_q[gi]        <= 1'b0;
               filt_q[gi]      <= 1'b0;
               filt_prev_q[gi] <= 1'b0;
            end else begin
               s1_q[gi]        <= pin_raw[gi];
               s2_q[gi]        <= s1_q[gi];
               s3_q[gi]        <= s2_q[gi];
               filt_q[gi]      <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
               filt_prev_q[gi] <= filt_q[gi];
            end
         end
      end
   endgenerate

   assign trig_edge = filt_q[0] & ~filt_prev_q[0];
   assign cap_rise  = filt_q[1] & ~filt_prev_q[1];
   assign cap_fall  = ~filt_q[1] & filt_prev_q[1];

   // Operating mode decode
   // Modes 00 and 11 belong to other timer functions and idle here
   always_comb begin
      case (ctrl_q.mode_select)
         `SPC_MODE_PULSE: begin
            // Other pin functions in this mode belong to PWM, not handled here
            op = (ctrl_q.pin_function == `SPC_PF_NONE) ? SPC_OP_PULSE : SPC_OP_IDLE;
         end
         `SPC_MODE_CAPTURE: begin
            op = SPC_OP_CAPTURE;
         end
         default: begin
            op = SPC_OP_IDLE;
         end
      endcase
   end

   // Timer clock prescaler
   // Divider free runs, so the first tick after a run rise may come early;
   // pulse width is exact only at divide by one
   always_comb begin
      case (ctrl_q.clk_sel)
         2'b00:   div_lim = `SPC_DIV_1;
         2'b01:   div_lim = `SPC_DIV_4;
         2'b10:   div_lim = `SPC_DIV_16;
         default: div_lim = `SPC_DIV_64;
      endcase
   end

   assign tick = (div_q >= div_lim);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + 1'b1;
      end
   end

   // Run bit edges and counter events
   // Hardware sets and clears of the run bit count as edges too
   assign run      = ctrl_q.counter_run_bit;
   assign run_rise = run & ~run_prev_q;
   assign run_fall = ~run & run_prev_q;

   assign cnt_inc = (cnt_q == `SPC_CNT_MAX) ? `SPC_CNT_ZERO : cnt_q + `SPC_CNT_ONE;

   // Pulse lasts A ticks plus one hclk cycle; A of zero wraps after 1024
   assign match_a = (op == SPC_OP_PULSE) & run & ~run_rise & tick &
                    (cnt_inc == cmpa_q);

   assign match_p = (op == SPC_OP_CAPTURE) & run & ~run_rise & tick &
                    (cmpp_q != `SPC_CNT_ZERO) & (cnt_q == cmpp_q);

   // Edge type decode; pin function 11 selects none of them
   assign cap_on_rise = (ctrl_q.pin_function == `SPC_PF_RISE);
   assign cap_on_fall = (ctrl_q.pin_function == `SPC_PF_FALL);
   assign cap_on_both = (ctrl_q.pin_function == `SPC_PF_BOTH);

   // Captures only while running: a stopped counter holds nothing new
   assign cap_hit = (op == SPC_OP_CAPTURE) & run &
                    ((cap_on_rise & cap_rise) | (cap_on_fall & cap_fall) |
                     (cap_on_both & (cap_rise | cap_fall)));

   assign set_a = match_a | cap_hit;

   // AHB-Lite slave: address phase captured, data phase acts
   // hsize is not decoded: every access is taken as a whole word
   // Unmapped offsets read as zero and drop writes
   assign take    = hsel & htrans[1] & hready;
   assign wr_en   = aph_q.valid & aph_q.write;
   assign wr_ctrl = wr_en & (aph_q.addr == `SPC_ADDR_CTRL);
   assign wr_cmpa = wr_en & (aph_q.addr == `SPC_ADDR_CMPA);
   assign wr_cmpp = wr_en & (aph_q.addr == `SPC_ADDR_CMPP);
   assign wr_stat = wr_en & (aph_q.addr == `SPC_ADDR_STAT);

   assign sel_ctrl = (haddr == `SPC_ADDR_CTRL);
   assign sel_cmpa = (haddr == `SPC_ADDR_CMPA);
   assign sel_cmpp = (haddr == `SPC_ADDR_CMPP);
   assign sel_stat = (haddr == `SPC_ADDR_STAT);

   assign rdata = sel_ctrl ? {21'h0, ctrl_q} :
                  sel_cmpa ? {22'h0, cmpa_q} :
                  sel_cmpp ? {22'h0, cmpp_q} :
                  sel_stat ? {13'h0, timer_out, flag_p_q, flag_a_q, 6'h00, cnt_q} :
                  32'h0000_0000;

   // Control: bus write first, then hardware set and clear of the run bit.
   // A compare A match beats a trigger edge in the same cycle.
   // A trigger edge while running changes nothing: run is already set
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = spc_ctrl_t'(hwdata[`SPC_CTRL_W-1:0]);
      end
      if ((op == SPC_OP_PULSE) && trig_edge) begin
         ctrl_d.counter_run_bit = 1'b1;
      end
      if (match_a) begin
         ctrl_d.counter_run_bit = 1'b0;
      end
   end

   // Capture beats a software write of the A value in the same cycle
   assign cmpa_d = cap_hit ? cnt_q : (wr_cmpa ? hwdata[`SPC_CNT_W-1:0] : cmpa_q);
   assign cmpp_d = wr_cmpp ? hwdata[`SPC_CNT_W-1:0] : cmpp_q;

   // Counter
   // Pulse mode parks the counter on the A value so it cannot match again
   always_comb begin
      cnt_d = cnt_q;
      if (run_rise) begin
         cnt_d = `SPC_CNT_ZERO;
      end else if (run && tick && (op == SPC_OP_PULSE)) begin
         cnt_d = match_a ? cmpa_q : cnt_inc;
      end else if (run && tick && (op == SPC_OP_CAPTURE)) begin
         cnt_d = match_p ? `SPC_CNT_ZERO : cnt_inc;
      end
   end

   // Pulse state: active from run rise until run falls in pulse mode
   always_comb begin
      active_d = active_q;
      if (run_rise) begin
         active_d = 1'b1;
      end else if (run_fall || (op != SPC_OP_PULSE)) begin
         active_d = 1'b0;
      end
   end

   // Pin shows the initial level XOR polarity invert while active, its inverse while idle
   // The idle level is driven too, so the pin never floats in pulse mode
   assign pin_level = (active_d ? ctrl_q.output_initial_level
                                : ~ctrl_q.output_initial_level)
                      ^ ctrl_q.output_polarity_invert;

   // Sticky flags: a set in the cycle of a clear wins
   assign flag_a_d = set_a | (flag_a_q & ~(wr_stat & hwdata[`SPC_STAT_FLAG_A]));
   assign flag_p_d = match_p | (flag_p_q & ~(wr_stat & hwdata[`SPC_STAT_FLAG_P]));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q     <= spc_ctrl_t'(`SPC_CTRL_RST);
         cmpa_q     <= `SPC_CNT_ZERO;
         cmpp_q     <= `SPC_CNT_ZERO;
         cnt_q      <= `SPC_CNT_ZERO;
         run_prev_q <= 1'b0;
         active_q   <= 1'b0;
         flag_a_q   <= 1'b0;
         flag_p_q   <= 1'b0;
      end else begin
         ctrl_q     <= ctrl_d;
         cmpa_q     <= cmpa_d;
         cmpp_q     <= cmpp_d;
         cnt_q      <= cnt_d;
         run_prev_q <= run;
         active_q   <= active_d;
         flag_a_q   <= flag_a_d;
         flag_p_q   <= flag_p_d;
      end
   end

   // Outputs straight from flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_out     <= 1'b0;
         timer_out_en  <= 1'b0;
         compare_a_req <= 1'b0;
         compare_p_req <= 1'b0;
      end else begin
         // Capture and other modes leave the pin undriven
         // Requests last one cycle; software polls the sticky flags instead
         timer_out     <= (op == SPC_OP_PULSE) ? pin_level : 1'b0;
         timer_out_en  <= (op == SPC_OP_PULSE);
         compare_a_req <= set_a;
         compare_p_req <= match_p;
      end
   end

   // Read data is fetched in the address phase, so it reflects state at
   // that edge; zero wait states keep hreadyout high throughout.
   // A read whose address phase meets a write's data phase sees the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_q     <= '0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         aph_q.valid <= take;
         aph_q.write <= hwrite;
         aph_q.addr  <= haddr;
         if (take && !hwrite) begin
            hrdata <= rdata;
         end
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

endmodule // spc_timer

`default_nettype wire

// ---- spc_timer_properties.sv ----
// Port checker for the single pulse / capture timer.
// Assumes the bind below onto spc_timer; one clock, async low reset.
`default_nettype none
module spc_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic timer_out,
   input wire logic timer_out_en,
   input wire logic compare_a_req,
   input wire logic compare_p_req
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_ok_ready: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_quiet_no_mode: assert property (!timer_out_en && !$past(timer_out_en) |-> !timer_out)
      else $error("output driven outside pulse mode");
   a_out_moves_en: assert property ($changed(timer_out) |-> timer_out_en || $past(timer_out_en))
      else $error("output moved without pulse mode");
   a_areq_one_cycle: assert property (compare_a_req |=> !compare_a_req)
      else $error("compare a request longer than one cycle");
   a_preq_one_cycle: assert property (compare_p_req |=> !compare_p_req)
      else $error("compare p request longer than one cycle");
   a_p_not_pulse: assert property (compare_p_req |-> !timer_out_en)
      else $error("p match acted in pulse mode");
   a_match_ends_pulse: assert property (compare_a_req && timer_out_en |-> ##[0:3] $changed(timer_out))
      else $error("a match did not end the pulse");
   a_pulse_stops: assert property (compare_a_req && timer_out_en |=> !compare_a_req [*3])
      else $error("counter kept matching after pulse end");
   c_pulse_match: cover property (compare_a_req && timer_out_en);
   c_capture: cover property (compare_a_req && !timer_out_en);
   c_p_match: cover property (compare_p_req);
endmodule // spc_chk

bind spc_timer spc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .timer_out(timer_out), .timer_out_en(timer_out_en),
   .compare_a_req(compare_a_req), .compare_p_req(compare_p_req));
`default_nettype wire

// ---- spc_pins.sv ----
// Far-side model: trigger source and capture signal source.
// Assumes the bench sets the wanted levels just after a rising edge.
`default_nettype none
module spc_pins (
   input  wire logic hclk,
   input  wire logic trig_lvl,
   input  wire logic cap_lvl,
   output var  logic external_trigger_pin,
   output var  logic capture_input_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      external_trigger_pin = 1'b0;
      capture_input_pin = 1'b0;
   end
   // Falling edge: pins are not aligned to the design clock
   always @(negedge hclk) begin
      external_trigger_pin <= trig_lvl;
      capture_input_pin <= cap_lvl;
   end
endmodule // spc_pins
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the single pulse / capture timer.
// Assumes spc_timer, spc_pins and the checker are compiled before it.
`default_nettype none
`include "spc_defs.svh"
module testbench import spc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [31:0] a, w, e;} spc_row_t;
   spc_row_t    rows [6] = '{'{`SPC_ADDR_STAT, 32'h0, 32'h0},
      '{`SPC_ADDR_CMPA, 32'hffff_ffff, 32'h3ff}, '{`SPC_ADDR_CMPP, 32'h1234, 32'h234},
      '{`SPC_ADDR_CTRL, 32'hffff_f7e0, 32'h7e0}, '{32'h10, 32'hffff_ffff, 32'h0},
      '{`SPC_ADDR_CTRL, 32'h0, 32'h0}};
   int          er [4] = '{1, 0, 1, 0};
   int          et [4] = '{1, 1, 2, 0};
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hwrite = 1'b0;
   logic        trig = 1'b0;
   logic        cap = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd, r1;
   logic        hreadyout, hresp, tout, ten, areq, preq, tpin, cpin;
   int          fails = 0;
   int          n_checks = 0;
   int          na = 0;
   int          np = 0;
   int          k;
   spc_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_trigger_pin(tpin),
      .capture_input_pin(cpin), .timer_out(tout), .timer_out_en(ten),
      .compare_a_req(areq), .compare_p_req(preq));
   spc_pins u_pins (.hclk(hclk), .trig_lvl(trig), .cap_lvl(cap),
      .external_trigger_pin(tpin), .capture_input_pin(cpin));
   initial begin
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (areq === 1'b1) na++;
      if (preq === 1'b1) np++;
   end
   task automatic end_sim;
      if (fails == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk_reg(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_pin(input string nm, input logic e, g);
      chk_reg(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Bounded wait for a level on the timer output; returns edges waited
   task automatic wait_out(input logic v, input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         @(posedge hclk);
         if (tout === v) break;
      end
      if (n > lim) begin
         fails++;
         end_sim;
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, d);
      int i;
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      for (i = 0; i < 2; i++) begin
         for (k = 0; k < 20; k++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
         end
         if (k == 20) begin
            fails++;
            end_sim;
         end
         htrans <= 2'h0;
         hwdata <= d;
      end
      rd = hrdata;
   endtask
   task automatic pulse(input int w);
      int n;
      wait_out(1'b1, 60, n);
      wait_out(1'b0, 2000, n);
      chk_reg("pulse width", 32'(w), 32'(n));
   endtask
   initial begin
      cyc(5);
      hresetn <= 1'b1;
      for (int r = 0; r < 6; r++) begin
         xfer(1'b1, rows[r].a, rows[r].w);
         xfer(1'b0, rows[r].a, 32'h0);
         chk_reg("readback", rows[r].e, rd);
      end
      xfer(1'b1, `SPC_ADDR_CMPA, 32'h5);
      xfer(1'b1, `SPC_ADDR_CTRL, 32'h2e);
      cyc(2);
      chk_pin("out enable", 1'b1, ten);
      xfer(1'b1, `SPC_ADDR_CTRL, 32'h3e);
      pulse(6);
      xfer(1'b0, `SPC_ADDR_STAT, 32'h0);
      chk_reg("status", 32'h0001_0005, rd);
      xfer(1'b0, `SPC_ADDR_CTRL, 32'h0);
      chk_reg("control", 32'h2e, rd);
      xfer(1'b1, `SPC_ADDR_STAT, 32'h0001_0000);
      trig <= 1'b1;
      cyc(3);
      trig <= 1'b0;
      pulse(6);
      xfer(1'b1, `SPC_ADDR_CMPA, 32'h3ff);
      xfer(1'b1, `SPC_ADDR_CTRL, 32'h3e);
      cyc(4);
      chk_pin("active", 1'b1, tout);
      xfer(1'b1, `SPC_ADDR_CTRL, 32'h2e);
      cyc(3);
      chk_pin("ended", 1'b0, tout);
      xfer(1'b1, `SPC_ADDR_CMPP, 32'h0);
      np = 0;
      for (int p = 0; p < 4; p++) begin
         xfer(1'b1, `SPC_ADDR_CTRL, 32'h71 | (32'(p) << 2));
         na = 0;
         cap <= 1'b1;
         cyc(12);
         chk_reg("captures rise", 32'(er[p]), 32'(na));
         cap <= 1'b0;
         cyc(12);
         chk_reg("captures all", 32'(et[p]), 32'(na));
      end
      chk_pin("no output", 1'b0, ten);
      chk_pin("no drive", 1'b0, tout);
      xfer(1'b0, `SPC_ADDR_CMPA, 32'h0);
      chk_pin("captured", 1'b1, rd[9:0] < 10'h3ff);
      xfer(1'b0, `SPC_ADDR_STAT, 32'h0);
      r1 = rd;
      xfer(1'b0, `SPC_ADDR_STAT, 32'h0);
      chk_pin("runs", 1'b1, rd[9:0] > r1[9:0]);
      cyc(1100);
      chk_reg("no p match", 32'h0, 32'(np));
      xfer(1'b0, `SPC_ADDR_STAT, 32'h0);
      chk_pin("no p flag", 1'b0, rd[17]);
      xfer(1'b1, `SPC_ADDR_CMPP, 32'h8);
      xfer(1'b1, `SPC_ADDR_CTRL, 32'h01);
      xfer(1'b1, `SPC_ADDR_CTRL, 32'h11);
      np = 0;
      cyc(40);
      chk_pin("p matches", 1'b1, np >= 3);
      xfer(1'b0, `SPC_ADDR_STAT, 32'h0);
      chk_pin("max count", 1'b1, rd[9:0] <= 10'h8 && rd[17]);
      hresetn <= 1'b0;
      cyc(2);
      hresetn <= 1'b1;
      xfer(1'b0, `SPC_ADDR_STAT, 32'h0);
      chk_reg("reset status", 32'h0, rd);
      xfer(1'b0, `SPC_ADDR_CTRL, 32'h0);
      chk_reg("reset control", 32'h0, rd);
      end_sim;
   end
endmodule // testbench
`default_nettype wire
